// ===== rtl/ext_irq_enable_priority_logic.sv
// interrupt enables, priorities, external inputs and arbitration
//
// Summary of operation
// - enable bit 1 gates cap greater-than request
// - enable bit 0 gates cap conversion-done request
// - enable register upper six bits read zero
// - enable anywhere; priority registers only page F
// - priority one bit 7: timer three
// - bit 5 one priority for both comparator edges
// - priority one bit 4: counter array
// - priority one bit 3: converter done
// - priority one bit 2: converter window
// - priority one bit 1: port match
// - priority one bit 0: smbus
// - priority two bit 1: cap greater-than
// - priority two bit 0 cap done; rest zero
// - polarity bit zero active low, one high
// - type bit one edge, zero level
// - pin watched without touching crossbar routing
// - pending flags are control bits 1 and 3
// - edge pending cleared when core vectors
// - level pending follows active input state
// - three-bit field picks port 0 pin
// - global enable zero blocks every source
`timescale 1ns/10ps
`include "ext_irq_consts.svh"
module ext_irq_enable_priority_logic
  import ext_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] sfr_page,
  output logic [7:0] rdata,
  input wire logic [7:0] port0_pins,
  input wire logic [6:0] periph_req,
  input wire logic cap_compare_flag,
  input wire logic cap_done_flag,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [3:0] irq_vector,
  output logic irq_high
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] extended_enable_two_r;
  logic [7:0] extended_priority_one_r;
  logic [1:0] extended_priority_two_r;
  logic [7:0] cfg_r;
  logic [3:0] timer_control_reg_r;
  logic [2:0] ctrl_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic act_a_prev_r;
  logic act_b_prev_r;
  logic irq_req_r;
  logic irq_req_nxt;
  logic [3:0] irq_vector_r;
  logic [3:0] irq_vector_nxt;
  logic irq_high_r;
  logic irq_high_nxt;
  svc_state_t svc_r;
  svc_state_t svc_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  wire on_page_f = (sfr_page == `PAGE_F);
  wire sel_extended_enable_two = (addr == `ADDR_EXT_ENABLE_TWO);
  wire sel_extended_priority_one = (addr == `ADDR_EXT_PRIO_ONE) && on_page_f;
  wire sel_extended_priority_two = (addr == `ADDR_EXT_PRIO_TWO) && on_page_f;
  wire sel_cfg = (addr == `ADDR_EXT_IRQ_CONFIG) && on_page_f;
  wire sel_timer_control_reg = (addr == `ADDR_TIMER_CONTROL);
  wire sel_ctrl = (addr == `ADDR_IRQ_CONTROL);
  wire wr_extended_enable_two = wr && sel_extended_enable_two;
  wire wr_extended_priority_one = wr && sel_extended_priority_one;
  wire wr_extended_priority_two = wr && sel_extended_priority_two;
  wire wr_cfg = wr && sel_cfg;
  wire wr_timer_control_reg = wr && sel_timer_control_reg;
  wire wr_ctrl = wr && sel_ctrl;

  ////////////////////////////////////////////////////////////////////////////////
  // external inputs: pin select, polarity, edge detect
  wire [2:0] a_pin_sel = cfg_r[2:0];
  wire [2:0] b_pin_sel = cfg_r[6:4];
  // observe only; the pins stay owned by whatever the crossbar routed there
  wire a_pin = pin_sync_r[a_pin_sel];
  wire b_pin = pin_sync_r[b_pin_sel];
  wire a_pol = cfg_r[`CFG_A_POL_BIT];
  wire b_pol = cfg_r[`CFG_B_POL_BIT];
  wire a_active = a_pol ? a_pin : ~a_pin;
  wire b_active = b_pol ? b_pin : ~b_pin;
  wire a_edge_mode = timer_control_reg_r[`TIMER_CONTROL_REG_A_EDGE_BIT];
  wire b_edge_mode = timer_control_reg_r[`TIMER_CONTROL_REG_B_EDGE_BIT];
  wire a_edge = a_active && !act_a_prev_r;
  wire b_edge = b_active && !act_b_prev_r;

  ////////////////////////////////////////////////////////////////////////////////
  // pending flags
  wire ack_a = irq_ack && (irq_vector_r == `SRC_EXT_A);
  wire ack_b = irq_ack && (irq_vector_r == `SRC_EXT_B);
  wire a_pend_sw = wr_timer_control_reg ? wdata[`TIMER_CONTROL_REG_A_PEND_BIT] : timer_control_reg_r[`TIMER_CONTROL_REG_A_PEND_BIT];
  wire b_pend_sw = wr_timer_control_reg ? wdata[`TIMER_CONTROL_REG_B_PEND_BIT] : timer_control_reg_r[`TIMER_CONTROL_REG_B_PEND_BIT];
  // edge mode: new edge wins over both software and vector clear
  wire a_pend_edge = a_edge || (a_pend_sw && !ack_a);
  wire b_pend_edge = b_edge || (b_pend_sw && !ack_b);
  wire a_pend_nxt = a_edge_mode ? a_pend_edge : a_active;
  wire b_pend_nxt = b_edge_mode ? b_pend_edge : b_active;
  wire [3:0] timer_control_reg_nxt = {b_pend_nxt,
                         wr_timer_control_reg ? wdata[`TIMER_CONTROL_REG_B_EDGE_BIT] : b_edge_mode,
                         a_pend_nxt,
                         wr_timer_control_reg ? wdata[`TIMER_CONTROL_REG_A_EDGE_BIT] : a_edge_mode};

  ////////////////////////////////////////////////////////////////////////////////
  // source masking and priority
  wire global_en = ctrl_r[`CTRL_GLOBAL_BIT - 5];
  // a level source that drops before recognition is simply lost
  wire [`NUM_SOURCES-1:0] raw_req = {
    cap_done_flag && extended_enable_two_r[0],
    cap_compare_flag && extended_enable_two_r[1],
    periph_req,
    timer_control_reg_r[`TIMER_CONTROL_REG_B_PEND_BIT] && ctrl_r[1],
    timer_control_reg_r[`TIMER_CONTROL_REG_A_PEND_BIT] && ctrl_r[0]
  };
  wire [`NUM_SOURCES-1:0] gated_req = global_en ? raw_req : '0;
  // periph_req bit 1 is comparator, both edges merged upstream
  wire [`NUM_SOURCES-1:0] prio_vec = {
    extended_priority_two_r[0],
    extended_priority_two_r[1],
    extended_priority_one_r[0],
    extended_priority_one_r[1],
    extended_priority_one_r[2],
    extended_priority_one_r[3],
    extended_priority_one_r[4],
    extended_priority_one_r[5],
    extended_priority_one_r[7],
    2'b00
  };
  wire [`NUM_SOURCES-1:0] hi_req = gated_req & prio_vec;
  wire [`NUM_SOURCES-1:0] lo_req = gated_req & ~prio_vec;

  function automatic logic [3:0] first_set(input logic [`NUM_SOURCES-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  ////////////////////////////////////////////////////////////////////////////////
  // service nesting
  wire in_high = (svc_r == SVC_HIGH) || (svc_r == SVC_HIGH_OVER_LOW);
  wire in_low = (svc_r == SVC_LOW);
  wire hi_ok = (|hi_req) && !in_high;
  wire lo_ok = (|lo_req) && (svc_r == SVC_IDLE);
  wire [3:0] hi_idx = first_set(hi_req);
  wire [3:0] lo_idx = first_set(lo_req);

  always_comb begin
    svc_nxt = svc_r;
    if (irq_ack && irq_req_r) begin
      if (irq_high_r) begin
        svc_nxt = in_low ? SVC_HIGH_OVER_LOW : SVC_HIGH;
      end else begin
        svc_nxt = SVC_LOW;
      end
    end else if (irq_return) begin
      unique case (svc_r)
        SVC_IDLE: svc_nxt = SVC_IDLE;
        SVC_LOW: svc_nxt = SVC_IDLE;
        SVC_HIGH: svc_nxt = SVC_IDLE;
        SVC_HIGH_OVER_LOW: svc_nxt = SVC_LOW;
        default: svc_nxt = SVC_IDLE;
      endcase
    end
  end

  // drop the request in the ack cycle so one ack takes one vector
  always_comb begin
    irq_req_nxt = 1'b0;
    irq_vector_nxt = irq_vector_r;
    irq_high_nxt = 1'b0;
    if (!irq_ack) begin
      if (hi_ok) begin
        irq_req_nxt = 1'b1;
        irq_vector_nxt = hi_idx;
        irq_high_nxt = 1'b1;
      end else if (lo_ok) begin
        irq_req_nxt = 1'b1;
        irq_vector_nxt = lo_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data
  wire [7:0] extended_enable_two_rd = {6'h00, extended_enable_two_r} & `EXTENDED_ENABLE_TWO_USED_MASK;
  wire [7:0] extended_priority_one_rd = extended_priority_one_r;
  wire [7:0] extended_priority_two_rd = {6'h00, extended_priority_two_r};
  wire [7:0] timer_control_reg_rd = {4'h0, timer_control_reg_r};
  wire [7:0] ctrl_rd = {ctrl_r[2], 4'h0, ctrl_r[1], 1'b0, ctrl_r[0]};

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      if (sel_extended_enable_two) begin
        rdata_nxt = extended_enable_two_rd;
      end else if (sel_extended_priority_one) begin
        rdata_nxt = extended_priority_one_rd;
      end else if (sel_extended_priority_two) begin
        rdata_nxt = extended_priority_two_rd;
      end else if (sel_cfg) begin
        rdata_nxt = cfg_r;
      end else if (sel_timer_control_reg) begin
        rdata_nxt = timer_control_reg_rd;
      end else if (sel_ctrl) begin
        rdata_nxt = ctrl_rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end else begin
      pin_meta_r <= port0_pins;
      pin_sync_r <= pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      extended_enable_two_r <= `RST_EXT_ENABLE_TWO;
    end else if (wr_extended_enable_two) begin
      extended_enable_two_r <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      extended_priority_one_r <= `RST_EXT_PRIO_ONE;
    end else if (wr_extended_priority_one) begin
      extended_priority_one_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      extended_priority_two_r <= `RST_EXT_PRIO_TWO;
    end else if (wr_extended_priority_two) begin
      extended_priority_two_r <= wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_r <= `RST_EXT_IRQ_CONFIG;
    end else if (wr_cfg) begin
      cfg_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= `RST_IRQ_CONTROL;
    end else if (wr_ctrl) begin
      ctrl_r <= {wdata[`CTRL_GLOBAL_BIT], wdata[`CTRL_B_EN_BIT], wdata[`CTRL_A_EN_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pending flags and edge modes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_control_reg_r <= `RST_TIMER_CONTROL;
    end else begin
      timer_control_reg_r <= timer_control_reg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // active level history for edge detect
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_a_prev_r <= 1'b0;
      act_b_prev_r <= 1'b0;
    end else begin
      act_a_prev_r <= a_active;
      act_b_prev_r <= b_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // service nesting state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      svc_r <= SVC_IDLE;
    end else begin
      svc_r <= svc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request to the core
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_req_r <= 1'b0;
      irq_vector_r <= 4'h0;
      irq_high_r <= 1'b0;
    end else begin
      irq_req_r <= irq_req_nxt;
      irq_vector_r <= irq_vector_nxt;
      irq_high_r <= irq_high_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign irq_req = irq_req_r;
  assign irq_vector = irq_vector_r;
  assign irq_high = irq_high_r;

endmodule : ext_irq_enable_priority_logic

// ===== rtl/ext_irq_consts.svh
// register offsets, field positions and reset values for the interrupt enable/priority block
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH
`define ADDR_EXT_ENABLE_TWO 8'he7
`define ADDR_EXT_PRIO_ONE 8'hce
`define ADDR_EXT_PRIO_TWO 8'hcf
`define ADDR_EXT_IRQ_CONFIG 8'he4
`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_IRQ_CONTROL 8'ha8
`define PAGE_F 8'h0f
`define RST_EXT_ENABLE_TWO 2'h0
`define RST_EXT_PRIO_ONE 8'h00
`define RST_EXT_PRIO_TWO 2'h0
`define RST_EXT_IRQ_CONFIG 8'h01
`define RST_TIMER_CONTROL 4'h0
`define RST_IRQ_CONTROL 3'h0
`define EXTENDED_ENABLE_TWO_USED_MASK 8'h03
`define EXTENDED_PRIORITY_ONE_RSVD_BIT 6
`define CFG_A_POL_BIT 3
`define CFG_B_POL_BIT 7
`define TIMER_CONTROL_REG_A_EDGE_BIT 0
`define TIMER_CONTROL_REG_A_PEND_BIT 1
`define TIMER_CONTROL_REG_B_EDGE_BIT 2
`define TIMER_CONTROL_REG_B_PEND_BIT 3
`define CTRL_GLOBAL_BIT 7
`define CTRL_A_EN_BIT 0
`define CTRL_B_EN_BIT 2
`define NUM_SOURCES 11
`define SRC_EXT_A 4'h0
`define SRC_EXT_B 4'h1
`define SRC_CAP_GREATER 4'h9
`define SRC_CAP_DONE 4'ha
`endif

// ===== rtl/ext_irq_pkg.sv
// types for the interrupt enable/priority block
package ext_irq_pkg;
  typedef enum logic [3:0] {
    SVC_IDLE = 4'b0001,
    SVC_LOW = 4'b0010,
    SVC_HIGH = 4'b0100,
    SVC_HIGH_OVER_LOW = 4'b1000
  } svc_state_t;
endpackage : ext_irq_pkg

// ===== sim/ext_src_model.sv
// external interrupt source driving one port 0 pin
`timescale 1ns/10ps
module ext_src_model (
  input wire logic clk,
  input wire logic [2:0] pin_sel,
  input wire logic level,
  output logic [7:0] pins
);
  logic [7:0] noise_r = 8'h5a;
  // pins owned by other peripherals toggle every cycle
  always_ff @(posedge clk) noise_r <= ~noise_r;
  // watched pin held at the commanded level until the bench drops it
  always_comb begin
    pins = noise_r;
    pins[pin_sel] = level;
  end
endmodule : ext_src_model

// ===== sim/ext_irq_checker.sv
// concurrent checks on the enable, priority and external input block
`timescale 1ns/10ps
module ext_irq_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] rdata,
  input wire logic cap_done_flag,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [3:0] irq_vector,
  input wire logic irq_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_enable_upper_zero: assert property (rd && addr == 8'he7 |=> rdata[7:2] == 6'h00)
    else $error("enable upper bits not zero");
  a_prio_two_rsvd: assert property (rd && addr == 8'hcf |=> rdata[7:2] == 6'h00)
    else $error("priority two upper bits not zero");
  a_prio_page_only: assert property (
    rd && addr[7:1] == 7'h67 && sfr_page != 8'h0f |=> rdata == 8'h00)
    else $error("priority register seen off page");
  a_enable_any_page: assert property (
    wr && addr == 8'he7 ##2 rd && addr == 8'he7 |=> rdata == ($past(wdata, 3) & 8'h03))
    else $error("enable readback wrong");
  a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_ack_drops_req: assert property (irq_ack |=> !irq_req)
    else $error("request stays after ack");
  a_ext_is_low: assert property (irq_req && irq_vector < 4'h2 |-> !irq_high)
    else $error("external source flagged high");
  a_vector_in_range: assert property (irq_req |-> irq_vector <= 4'ha)
    else $error("vector out of range");
  a_done_needs_flag: assert property (
    irq_req && irq_vector == 4'ha |-> $past(cap_done_flag) || $past(cap_done_flag, 2))
    else $error("done request without flag");
  c_high_ack: cover property (irq_ack && irq_high);
  c_ext_req: cover property (irq_req && irq_vector == 4'h0);
  c_read_data: cover property (rd ##1 rdata != 8'h00);
endmodule : ext_irq_checker
bind ext_irq_enable_priority_logic ext_irq_checker chk (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .sfr_page(sfr_page), .rdata(rdata),
  .cap_done_flag(cap_done_flag), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_high(irq_high));

// ===== sim/tb_ext_irq_enable_priority_logic.sv
// self-checking bench for the enable, priority and external input block
`timescale 1ns/10ps
module tb_ext_irq_enable_priority_logic;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, cmp_f = 0, done_f = 0;
  logic irq_ack = 0, irq_return = 0, level = 0, irq_req, irq_high;
  logic [7:0] addr = 0, wdata = 0, sfr_page = 8'h0f, rdata, pins, v;
  logic [6:0] periph_req = 0;
  logic [2:0] pin_sel = 3'h5;
  logic [3:0] irq_vector;
  int n_errors = 0, n_compared = 0, cyc = 0;
  typedef struct packed {logic [7:0] pg, a, d, e;} row_t;
  row_t rows [7] = '{'{8'h0f, 8'he7, 8'hff, 8'h03}, '{8'h00, 8'he7, 8'h02, 8'h02},
    '{8'h0f, 8'hce, 8'hbf, 8'hbf}, '{8'h0f, 8'hcf, 8'hff, 8'h03},
    '{8'h00, 8'hce, 8'h3f, 8'h00}, '{8'h00, 8'hcf, 8'h01, 8'h00},
    '{8'h0f, 8'h3c, 8'hff, 8'h00}};
  ext_irq_enable_priority_logic uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .sfr_page(sfr_page), .rdata(rdata), .port0_pins(pins),
    .periph_req(periph_req), .cap_compare_flag(cmp_f), .cap_done_flag(done_f),
    .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_high(irq_high));
  ext_src_model src (.clk(clk), .pin_sel(pin_sel), .level(level), .pins(pins));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task automatic rreg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    v = rdata;
  endtask : rreg
  task automatic wait_req();
    for (int i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge clk);
    check(irq_req, 1);
  endtask : wait_req
  task automatic pulse(bit ret);
    @(posedge clk);
    if (ret) irq_return <= 1;
    else irq_ack <= 1;
    @(posedge clk);
    irq_return <= 0;
    irq_ack <= 0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    foreach (rows[i]) begin
      sfr_page <= rows[i].pg;
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a);
      check(v, rows[i].e);
    end
    sfr_page <= 8'h0f;
    rreg(8'hce);
    check(v, 8'hbf);
    // capacitive sources: mask, global gate, priority
    wreg(8'ha8, 8'h80);
    wreg(8'he7, 8'h00);
    wreg(8'hcf, 8'h02);
    cmp_f <= 1;
    repeat (6) @(posedge clk);
    check(irq_req, 0);
    wreg(8'he7, 8'h03);
    wait_req();
    check({irq_high, irq_vector}, 8'h19);
    wreg(8'ha8, 8'h00);
    repeat (3) @(posedge clk);
    check(irq_req, 0);
    @(posedge clk);
    cmp_f <= 0;
    done_f <= 1;
    wreg(8'hcf, 8'h01);
    wreg(8'ha8, 8'h80);
    wait_req();
    check({irq_high, irq_vector}, 8'h1a);
    @(posedge clk);
    done_f <= 0;
    // fixed order, then a high request preempts a low routine
    wreg(8'hce, 8'h00);
    periph_req <= 7'h41;
    wait_req();
    check({irq_high, irq_vector}, 8'h02);
    pulse(0);
    wreg(8'hce, 8'h01);
    wait_req();
    check({irq_high, irq_vector}, 8'h18);
    pulse(0);
    periph_req <= 0;
    pulse(1);
    pulse(1);
    // level mode, both inputs active high on pin 5
    wreg(8'he4, 8'hdd);
    wreg(8'h88, 8'h00);
    wreg(8'ha8, 8'h81);
    level <= 1;
    wait_req();
    check({irq_high, irq_vector}, 8'h00);
    pulse(0);
    rreg(8'h88);
    check(v & 8'h0a, 8'h0a);
    level <= 0;
    repeat (5) @(posedge clk);
    rreg(8'h88);
    check(v & 8'h0a, 8'h00);
    pulse(1);
    repeat (4) @(posedge clk);
    check(irq_req, 0);
    // edge mode, active low: falling edge sets, vectoring clears its own flag
    wreg(8'ha8, 8'h80);
    level <= 1;
    wreg(8'he4, 8'h55);
    wreg(8'h88, 8'h05);
    wreg(8'ha8, 8'h81);
    level <= 0;
    wait_req();
    check({irq_high, irq_vector}, 8'h00);
    rreg(8'h88);
    check(v & 8'h0a, 8'h0a);
    pulse(0);
    rreg(8'h88);
    check(v & 8'h0a, 8'h08);
    pulse(1);
    repeat (4) @(posedge clk);
    check(irq_req, 0);
    // mid-run reset
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    rreg(8'he7);
    check(v, 8'h00);
    rreg(8'hce);
    check(v, 8'h00);
    rreg(8'he4);
    check(v, 8'h01);
    check(irq_req, 0);
    tally_and_finish();
  end
endmodule : tb_ext_irq_enable_priority_logic
